// ### hdl/vcibc_pkg.sv
// Constants and carrier types for the virtual split-point and control block
package vcibc_pkg;
  // System-register encoding shared by both registers, op2 selects one
  localparam logic [1:0] ENC_OP0      = 2'h3;
  localparam logic [2:0] ENC_OP1      = 3'h0;
  localparam logic [3:0] ENC_CRN      = 4'hc;
  localparam logic [3:0] ENC_CRM      = 4'hc;
  localparam logic [2:0] OP2_SPLIT1   = 3'h3;
  localparam logic [2:0] OP2_CTRL     = 3'h4;
  // Exception levels and syndrome class
  localparam logic [1:0] EL_0         = 2'h0;
  localparam logic [1:0] EL_1         = 2'h1;
  localparam logic [1:0] EL_2         = 2'h2;
  localparam logic [1:0] EL_3         = 2'h3;
  localparam logic [5:0] SYND_SYSREG  = 6'h18;
  // Control register field positions
  localparam int         CTL_EXT_POS  = 19;
  localparam int         CTL_RSS_POS  = 18;
  localparam int         CTL_A3V_POS  = 15;
  localparam int         CTL_LOCAL_SYSTEM_ERROR_SUPPORT_POS = 14;
  localparam int         CTL_IDW_LSB  = 11;
  localparam int         CTL_PRIW_LSB = 8;
  localparam int         CTL_MODE_POS = 1;
  localparam int         CTL_COMMON_SPLIT_POINT_POS = 0;
  // Reset values and split limits
  localparam logic       MODE_RST     = 1'b0;
  localparam logic       COMMON_SPLIT_POINT_RST     = 1'b0;
  localparam logic [2:0] SPLIT_MAX    = 3'h7;
  localparam logic [2:0] SPLIT_STEP   = 3'h1;
  localparam logic [7:0] MASK_ALL     = 8'hff;

  typedef enum logic [1:0] {
    RES_OK    = 2'h0,
    RES_UNDEF = 2'h1,
    RES_EXT   = 2'h2,
    RES_TRAP  = 2'h3
  } vcibc_result_e;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } vcibc_enc_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  el;
    vcibc_enc_s  enc;
    logic [63:0] wdata;
  } vcibc_req_s;

  typedef struct packed {
    logic level1_sysreg_enable;
    logic level2_sysreg_enable;
    logic level3_sysreg_enable;
    logic el2_enabled;
    logic el3_present;
    logic trap_all_group1;
    logic trap_common;
    logic irq_route_to_hypervisor;
    logic fiq_route_to_hypervisor;
    logic irq_route_to_monitor;
    logic fiq_route_to_monitor;
    logic nonsecure_state_bit;
  } vcibc_ctx_s;

  typedef struct packed {
    logic          valid;
    vcibc_result_e result;
    logic [1:0]    trap_el;
    logic [5:0]    syndrome;
    logic [63:0]   rdata;
  } vcibc_resp_s;
endpackage

// ### hdl/vcibc_top.sv
// Virtual group 1 split point and virtual control register with access routing
// Summary of operation
// - Split value 1..7 moves preemption/subpriority boundary from bit 1 to bit 7
// - Writing zero to the group 1 split stores its reset value
// - Common split, nonsecure level 1: read group 0 plus one saturated, ignore writes
// - Common split, secure level 1: read group 0, writes go to group 0
// - Group 1 split resets to minimum group 0 value plus one
// - Writes below the reset value store the reset value
// - Group 1 split decoded at op0 3, op1 0, CRn 12, CRm 12, op2 3
// - Access from level 0 is an undefined instruction
// - Level 1 with its enable clear traps to level 1, class 0x18
// - Level 1, level 2 on, trap-all set: trap to level 2 after enable check
// - Level 1, level 2 on, hypervisor routing set: use the virtual register
// - Monitor routing with level 3 present traps to level 3, class 0x18
// - No trap with level 3: secure copy if state bit 0, else nonsecure copy
// - Level 2 with its enable clear traps to level 2 first
// - Bit 19 reports extended identifier range support, read-only
// - Bit 18 reports targeted software interrupt range support, read-only
// - Bit 15 reports nonzero affinity 3 support, writes ignored
// - Bit 14 reports local system error support, writes ignored
// - Bits 13:11 report identifier width code, writes ignored
// - Bits 10:8 report priority bits minus one, at least five bits
// - Bit 1 selects split completion mode, written by software
// - Bit 0 selects common split point governing both groups
`timescale 1ns/1ps
module vcibc_top #(
  parameter logic [2:0] G1_SPLIT_RST = 3'h3,
  parameter logic       EXT_RANGE    = 1'b0,
  parameter logic       TGT_RANGE    = 1'b0,
  parameter logic       AFF3_VALID   = 1'b0,
  parameter logic       SERR_SUPPORT = 1'b0,
  parameter logic [2:0] ID_WIDTH     = 3'h0,
  parameter logic [2:0] PRI_WIDTH    = 3'h4
) (
  input  wire logic                  clock_i,
  input  wire logic                  resetn_i,
  input  wire logic                  ce_i,
  input  wire vcibc_pkg::vcibc_req_s req_i,
  input  wire vcibc_pkg::vcibc_ctx_s ctx_i,
  input  wire logic [2:0]            vg0_split_i,
  output vcibc_pkg::vcibc_resp_s     resp_o,
  output logic                       vg0_wr_o,
  output logic [2:0]                 vg0_wdata_o,
  output logic                       split_completion_mode_o,
  output logic                       common_split_point_o,
  output logic [7:0]                 vg1_preempt_mask_o
);

  function automatic logic enc_hit(input vcibc_pkg::vcibc_enc_s e, input logic [2:0] op2);
    enc_hit = (e.op0 == vcibc_pkg::ENC_OP0) && (e.op1 == vcibc_pkg::ENC_OP1) &&
              (e.crn == vcibc_pkg::ENC_CRN) && (e.crm == vcibc_pkg::ENC_CRM) &&
              (e.op2 == op2);
  endfunction

  // Raise a written split value to the floor
  function automatic logic [2:0] split_floor(input logic [2:0] v);
    split_floor = (v < G1_SPLIT_RST) ? G1_SPLIT_RST : v;
  endfunction

  logic [2:0] vg1_split;
  logic [2:0] sec_split;
  logic [2:0] ns_split;
  logic       mode;
  logic       common_split_point;

  wire hit_split = enc_hit(req_i.enc, vcibc_pkg::OP2_SPLIT1);
  wire hit_ctrl  = enc_hit(req_i.enc, vcibc_pkg::OP2_CTRL);
  wire accept    = ce_i & req_i.valid & (hit_split | hit_ctrl);

  wire el0 = (req_i.el == vcibc_pkg::EL_0);
  wire el1 = (req_i.el == vcibc_pkg::EL_1);
  wire el2 = (req_i.el == vcibc_pkg::EL_2);
  wire el3 = (req_i.el == vcibc_pkg::EL_3);
  wire sre1 = ctx_i.level1_sysreg_enable;
  wire sre2 = ctx_i.level2_sysreg_enable;
  wire sre3 = ctx_i.level3_sysreg_enable;

  // Control register uses the common trap, either hypervisor routing bit and both monitor routing bits
  wire trap_bit = hit_split ? ctx_i.trap_all_group1 : ctx_i.trap_common;
  wire virt_bit = hit_split ? ctx_i.irq_route_to_hypervisor :
                  (ctx_i.irq_route_to_hypervisor | ctx_i.fiq_route_to_hypervisor);
  wire mon_bit  = hit_split ? ctx_i.irq_route_to_monitor :
                  (ctx_i.irq_route_to_monitor & ctx_i.fiq_route_to_monitor);

  // Check order: enable, then trap-all, then routing, then monitor
  wire go_el1   = el1 & sre1;
  wire trap_l1  = el1 & ~sre1;
  wire trap_l2  = (go_el1 & ctx_i.el2_enabled & trap_bit) | (el2 & ~sre2);
  wire to_virt  = go_el1 & ctx_i.el2_enabled & ~trap_bit & virt_bit;
  wire pass_up  = (go_el1 & ~(ctx_i.el2_enabled & (trap_bit | virt_bit))) | (el2 & sre2);
  wire mon_trap = ctx_i.el3_present & mon_bit;
  wire trap_l3  = (pass_up & mon_trap) | (el3 & ~sre3);
  wire to_phys  = (pass_up & ~mon_trap) | (el3 & sre3);
  wire use_sec  = ctx_i.el3_present & ~ctx_i.nonsecure_state_bit;
  wire ns_view  = ctx_i.nonsecure_state_bit;

  // Common split view of group 1: nonsecure reads group 0 plus one, saturated; secure reads group 0
  wire [2:0] g0_plus = (vg0_split_i == vcibc_pkg::SPLIT_MAX) ? vcibc_pkg::SPLIT_MAX :
                       vg0_split_i + vcibc_pkg::SPLIT_STEP;
  wire [2:0] virt_view = ~common_split_point ? vg1_split : (ns_view ? g0_plus : vg0_split_i);
  wire [2:0] phys_view = use_sec ? sec_split : ns_split;
  wire [2:0] wr_split  = split_floor(req_i.wdata[2:0]);

  wire [63:0] ctl_word =
      (64'(EXT_RANGE)    << vcibc_pkg::CTL_EXT_POS)  |
      (64'(TGT_RANGE)    << vcibc_pkg::CTL_RSS_POS)  |
      (64'(AFF3_VALID)   << vcibc_pkg::CTL_A3V_POS)  |
      (64'(SERR_SUPPORT) << vcibc_pkg::CTL_LOCAL_SYSTEM_ERROR_SUPPORT_POS) |
      (64'(ID_WIDTH)     << vcibc_pkg::CTL_IDW_LSB)  |
      (64'(PRI_WIDTH)    << vcibc_pkg::CTL_PRIW_LSB) |
      (64'(mode)         << vcibc_pkg::CTL_MODE_POS) |
      (64'(common_split_point)         << vcibc_pkg::CTL_COMMON_SPLIT_POINT_POS);

  // Physical control copies live elsewhere; the block only reports the route
  wire [63:0] rd_word = hit_ctrl ? ctl_word :
                        {61'h0, (to_virt ? virt_view : phys_view)};
  wire rd_here = ~req_i.write & (to_virt | (to_phys & hit_split));

  vcibc_pkg::vcibc_result_e next_result;
  assign next_result = el0                           ? vcibc_pkg::RES_UNDEF :
                       (trap_l1 | trap_l2 | trap_l3) ? vcibc_pkg::RES_TRAP :
                       (hit_ctrl & to_phys)          ? vcibc_pkg::RES_EXT :
                                                       vcibc_pkg::RES_OK;
  wire [1:0] next_trap_el = trap_l1 ? vcibc_pkg::EL_1 :
                            trap_l2 ? vcibc_pkg::EL_2 :
                            trap_l3 ? vcibc_pkg::EL_3 : vcibc_pkg::EL_0;
  wire is_trap = (next_result == vcibc_pkg::RES_TRAP);

  wire wr_ok     = accept & req_i.write & ~el0 & (to_virt | to_phys);
  wire wr_vg1    = wr_ok & hit_split & to_virt & ~common_split_point;
  wire wr_vg0    = wr_ok & hit_split & to_virt & common_split_point & ~ns_view;
  wire wr_sec    = wr_ok & hit_split & to_phys & use_sec;
  wire wr_ns     = wr_ok & hit_split & to_phys & ~use_sec;
  wire wr_ctl    = wr_ok & hit_ctrl & to_virt;

  // Group 1 preemption mask; with common split the group 0 value governs
  wire [3:0] g1_shift = common_split_point ? ({1'b0, vg0_split_i} + 4'h1) : {1'b0, vg1_split};
  wire [7:0] next_mask = (g1_shift > 4'h7) ? 8'h00 : (vcibc_pkg::MASK_ALL << g1_shift);

  vcibc_pkg::vcibc_resp_s next_resp;
  assign next_resp.valid    = accept;
  assign next_resp.result   = accept ? next_result : vcibc_pkg::RES_OK;
  assign next_resp.trap_el  = (accept & is_trap) ? next_trap_el : vcibc_pkg::EL_0;
  assign next_resp.syndrome = (accept & is_trap) ? vcibc_pkg::SYND_SYSREG : 6'h00;
  assign next_resp.rdata    = (accept & rd_here & ~is_trap) ? rd_word : 64'h0;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vg1_split <= G1_SPLIT_RST;
      sec_split <= G1_SPLIT_RST;
      ns_split  <= G1_SPLIT_RST;
      mode      <= vcibc_pkg::MODE_RST;
      common_split_point      <= vcibc_pkg::COMMON_SPLIT_POINT_RST;
    end else if (ce_i) begin
      if (wr_vg1) vg1_split <= wr_split;
      if (wr_sec) sec_split <= wr_split;
      if (wr_ns)  ns_split  <= wr_split;
      if (wr_ctl) begin
        mode <= req_i.wdata[vcibc_pkg::CTL_MODE_POS];
        common_split_point <= req_i.wdata[vcibc_pkg::CTL_COMMON_SPLIT_POINT_POS];
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resp_o             <= '0;
      vg0_wr_o           <= 1'b0;
      vg0_wdata_o        <= 3'h0;
      vg1_preempt_mask_o <= 8'h00;
    end else if (ce_i) begin
      resp_o             <= next_resp;
      vg0_wr_o           <= wr_vg0;
      vg0_wdata_o        <= wr_vg0 ? req_i.wdata[2:0] : 3'h0;
      vg1_preempt_mask_o <= next_mask;
    end
  end

  assign split_completion_mode_o = mode;
  assign common_split_point_o    = common_split_point;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_undef_level0: assert property (
    accept && el0 |=> resp_o.valid && resp_o.result == vcibc_pkg::RES_UNDEF)
    else $error("Level 0 access not undefined");
  a_trap_level1: assert property (
    accept && el1 && !sre1 |=> resp_o.result == vcibc_pkg::RES_TRAP &&
      resp_o.trap_el == vcibc_pkg::EL_1 && resp_o.syndrome == 6'h18)
    else $error("Level 1 enable trap missing");
  a_trap_all_g1: assert property (
    accept && hit_split && el1 && sre1 && ctx_i.el2_enabled && ctx_i.trap_all_group1
      |=> resp_o.trap_el == vcibc_pkg::EL_2 && resp_o.syndrome == 6'h18)
    else $error("Trap-all not sent to level 2");
  a_trap_level2: assert property (
    accept && el2 && !sre2 |=> resp_o.trap_el == vcibc_pkg::EL_2)
    else $error("Level 2 enable trap missing");
  a_monitor_trap: assert property (
    accept && hit_split && el2 && sre2 && ctx_i.el3_present && ctx_i.irq_route_to_monitor
      |=> resp_o.trap_el == vcibc_pkg::EL_3 && resp_o.result == vcibc_pkg::RES_TRAP)
    else $error("Monitor trap missing");
  a_split_floor: assert property (
    vg1_split >= G1_SPLIT_RST && sec_split >= G1_SPLIT_RST && ns_split >= G1_SPLIT_RST)
    else $error("Split copy below reset value");
  a_zero_write: assert property (
    wr_vg1 && req_i.wdata[2:0] == 3'h0 |=> vg1_split == G1_SPLIT_RST)
    else $error("Zero write not forced to reset value");
  a_ns_common_read: assert property (
    accept && !req_i.write && hit_split && to_virt && common_split_point && ns_view && !el0
      |=> resp_o.rdata[2:0] == (($past(vg0_split_i) == 3'h7) ? 3'h7 : $past(vg0_split_i) + 3'h1))
    else $error("Common split read not saturated plus one");
  a_sec_common_write: assert property (
    accept && req_i.write && hit_split && to_virt && common_split_point && !ns_view && !el0
      |=> vg0_wr_o && vg0_wdata_o == $past(req_i.wdata[2:0]) && $stable(vg1_split))
    else $error("Secure common write not steered to group 0");
  a_ctrl_readonly: assert property (
    resp_o.valid && $past(hit_ctrl) && resp_o.result == vcibc_pkg::RES_OK && !$past(req_i.write)
      |-> resp_o.rdata[10:8] == PRI_WIDTH && resp_o.rdata[63:20] == 44'h0)
    else $error("Control read fields wrong");
  a_range_bits: assert property (
    resp_o.valid && resp_o.result == vcibc_pkg::RES_OK && $past(hit_ctrl) && !$past(req_i.write)
      |-> resp_o.rdata[vcibc_pkg::CTL_EXT_POS] == EXT_RANGE &&
          resp_o.rdata[vcibc_pkg::CTL_RSS_POS] == TGT_RANGE)
    else $error("Range feature bits wrong");
  a_local_bits: assert property (
    resp_o.valid && resp_o.result == vcibc_pkg::RES_OK && $past(hit_ctrl) && !$past(req_i.write)
      |-> resp_o.rdata[vcibc_pkg::CTL_A3V_POS] == AFF3_VALID &&
          resp_o.rdata[vcibc_pkg::CTL_LOCAL_SYSTEM_ERROR_SUPPORT_POS] == SERR_SUPPORT)
    else $error("Affinity or error feature bits wrong");
  a_id_width: assert property (
    resp_o.valid && resp_o.result == vcibc_pkg::RES_OK && $past(hit_ctrl) && !$past(req_i.write)
      |-> resp_o.rdata[13:11] == ID_WIDTH && resp_o.rdata[17:16] == 2'h0 &&
          resp_o.rdata[7:2] == 6'h0)
    else $error("Identifier width or reserved bits wrong");
  a_ctrl_write: assert property (
    accept && req_i.write && hit_ctrl && to_virt
      |=> mode == $past(req_i.wdata[vcibc_pkg::CTL_MODE_POS]) &&
          common_split_point == $past(req_i.wdata[vcibc_pkg::CTL_COMMON_SPLIT_POINT_POS]))
    else $error("Control write not stored");

  // Routing checks are built from the context bits, not from the route wires
  a_virt_read: assert property (
    accept && hit_split && !req_i.write && el1 && sre1 && ctx_i.el2_enabled &&
      !ctx_i.trap_all_group1 && ctx_i.irq_route_to_hypervisor && !common_split_point
      |=> resp_o.result == vcibc_pkg::RES_OK && resp_o.rdata[2:0] == $past(vg1_split))
    else $error("Virtual split read not routed");
  a_virt_write: assert property (
    accept && hit_split && req_i.write && el1 && sre1 && ctx_i.el2_enabled &&
      !ctx_i.trap_all_group1 && ctx_i.irq_route_to_hypervisor && !common_split_point
      |=> vg1_split == split_floor($past(req_i.wdata[2:0])))
    else $error("Virtual split write not stored");
  a_secure_copy: assert property (
    accept && hit_split && req_i.write && el3 && sre3 && ctx_i.el3_present &&
      !ctx_i.nonsecure_state_bit
      |=> sec_split == split_floor($past(req_i.wdata[2:0])) && $stable(ns_split))
    else $error("Secure copy not written");
  a_nonsecure_copy: assert property (
    accept && hit_split && req_i.write && el3 && sre3 && ctx_i.nonsecure_state_bit
      |=> ns_split == split_floor($past(req_i.wdata[2:0])) && $stable(sec_split))
    else $error("Nonsecure copy not written");
  a_level3_enable: assert property (
    accept && el3 && !sre3 |=> resp_o.trap_el == vcibc_pkg::EL_3 &&
      resp_o.result == vcibc_pkg::RES_TRAP)
    else $error("Level 3 enable trap missing");
  a_enable_first: assert property (
    accept && el1 && !sre1 && ctx_i.el2_enabled && ctx_i.trap_all_group1
      |=> resp_o.trap_el == vcibc_pkg::EL_1)
    else $error("Trap-all checked before enable");
  a_level2_first: assert property (
    accept && el2 && !sre2 && ctx_i.el3_present && ctx_i.irq_route_to_monitor
      |=> resp_o.trap_el == vcibc_pkg::EL_2 && resp_o.result == vcibc_pkg::RES_TRAP)
    else $error("Level 2 enable not checked first");

  // Refused, undefined and trapped accesses must leave every copy alone
  a_ns_common_write: assert property (
    accept && req_i.write && hit_split && to_virt && common_split_point && ns_view
      |=> $stable(vg1_split) && !vg0_wr_o && resp_o.result == vcibc_pkg::RES_OK)
    else $error("Nonsecure common split write not ignored");
  a_undef_no_write: assert property (
    accept && el0 |=> $stable(vg1_split) && $stable(sec_split) && $stable(ns_split) &&
      $stable(common_split_point) && !vg0_wr_o)
    else $error("Level 0 access changed state");
  a_trap_no_write: assert property (
    accept && is_trap |=> $stable(vg1_split) && $stable(sec_split) && $stable(ns_split) &&
      $stable(mode) && resp_o.syndrome == 6'h18 && resp_o.rdata == 64'h0)
    else $error("Trapped access changed state");
  a_reset_split: assert property (
    $rose(resetn_i) |-> vg1_split == G1_SPLIT_RST && G1_SPLIT_RST != 3'h0)
    else $error("Split reset value wrong");
  a_ce_hold: assert property (
    !ce_i |=> $stable(resp_o) && $stable(vg1_split) && $stable(common_split_point) &&
      $stable(vg1_preempt_mask_o))
    else $error("State moved with clock enable low");

  // The mask lags the split value by one enabled edge
  a_mask_separate: assert property (
    ce_i && !common_split_point |=> vg1_preempt_mask_o == (vcibc_pkg::MASK_ALL << $past(vg1_split)))
    else $error("Group 1 preemption mask wrong");
  a_mask_common: assert property (
    ce_i && common_split_point |=> vg1_preempt_mask_o ==
      (vcibc_pkg::MASK_ALL << ({1'b0, $past(vg0_split_i)} + 4'h1)))
    else $error("Common split mask wrong");

  c_virt_write: cover property (wr_vg1);
  c_ctrl_write: cover property (wr_ctl ##1 common_split_point);
  c_monitor_trap: cover property (accept && trap_l3);
  c_common_read: cover property (accept && hit_split && to_virt && common_split_point && !req_i.write);
  c_level0: cover property (accept && el0);
endmodule // vcibc_top

// ### tb/vcibc_core_model.sv
// Processor core model issuing system-register accesses to the block
`timescale 1ns/1ps
module vcibc_core_model (
  input  wire logic             clock_i,
  output vcibc_pkg::vcibc_req_s req_o,
  output vcibc_pkg::vcibc_ctx_s ctx_o
);
  initial begin
    req_o = '0;
    ctx_o = '0;
  end

  // One request per call, driven from a falling edge and held until the next access or idle call
  task automatic access(input logic wr, input logic [1:0] el, input logic [2:0] op2,
                        input logic [63:0] wd, input logic [11:0] cx);
    @(negedge clock_i);
    req_o.valid <= 1'b1;
    req_o.write <= wr;
    req_o.el    <= el;
    req_o.enc   <= {vcibc_pkg::ENC_OP0, vcibc_pkg::ENC_OP1, vcibc_pkg::ENC_CRN,
                    vcibc_pkg::ENC_CRM, op2};
    req_o.wdata <= wd;
    ctx_o       <= cx;
  endtask

  // Released data and encoding lines flip so stale data can never pass for a fresh request
  task automatic idle();
    @(negedge clock_i);
    req_o.valid <= 1'b0;
    req_o.wdata <= ~req_o.wdata;
    req_o.enc   <= ~req_o.enc;
  endtask
endmodule // vcibc_core_model

// ### tb/tb.sv
// Self-checking bench for the virtual split-point and control block
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    vcibc_pkg::vcibc_resp_s r;
    logic                   w;
    logic [2:0]             d;
  } vcibc_note_s;
  localparam logic [2:0]  SP = vcibc_pkg::OP2_SPLIT1;
  localparam logic [2:0]  CT = vcibc_pkg::OP2_CTRL;
  // Context words: virtual nonsecure/secure, physical nonsecure/secure
  localparam logic [11:0] VN = 12'hf91;
  localparam logic [11:0] VS = 12'hf90;
  localparam logic [11:0] PN = 12'he81;
  localparam logic [11:0] PS = 12'he80;
  logic                   clock_i  = 1'b0;
  logic                   resetn_i = 1'b0;
  logic                   ce_i     = 1'b1;
  logic [2:0]             vg0      = 3'h2;
  logic [15:0]            seed     = 16'h57a1;
  logic [2:0]             exp3;
  int                     error_cnt = 0;
  int                     checked   = 0;
  vcibc_note_s            note_q[$];
  vcibc_note_s            got;
  vcibc_note_s            exp;
  vcibc_pkg::vcibc_req_s  req;
  vcibc_pkg::vcibc_ctx_s  ctx;
  vcibc_pkg::vcibc_resp_s resp;
  logic                   vg0_wr;
  logic [2:0]             vg0_wd;
  logic                   mode;
  logic                   common_split_point;
  logic [7:0]             mask;

  always #2.5 clock_i = ~clock_i;

  vcibc_core_model u_vcibc_core_model (.clock_i(clock_i), .req_o(req), .ctx_o(ctx));

  vcibc_top #(.EXT_RANGE(1'b1), .AFF3_VALID(1'b1), .ID_WIDTH(3'h1)) u_vcibc_top (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req), .ctx_i(ctx),
    .vg0_split_i(vg0), .resp_o(resp), .vg0_wr_o(vg0_wr), .vg0_wdata_o(vg0_wd),
    .split_completion_mode_o(mode), .common_split_point_o(common_split_point), .vg1_preempt_mask_o(mask));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk_note(input vcibc_note_s g, input vcibc_note_s e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_mask(input logic [2:0] s);
    logic [7:0] e;
    e = 8'hff << s;
    chk_val({56'h0, mask}, {56'h0, e});
  endtask

  // Notes the expected answer for split or control accesses, then hands the request to the core model
  task automatic run(input logic wr, input logic [1:0] el, input logic [2:0] op2,
                     input logic [63:0] wd, input logic [11:0] cx, input logic [1:0] res,
                     input logic [1:0] tel, input logic [63:0] rd,
                     input logic w = 1'b0, input logic [2:0] d = 3'h0);
    vcibc_note_s n;
    n.r.valid    = 1'b1;
    n.r.result   = vcibc_pkg::vcibc_result_e'(res);
    n.r.trap_el  = tel;
    n.r.syndrome = (res == 2'h3) ? vcibc_pkg::SYND_SYSREG : 6'h0;
    n.r.rdata    = rd;
    n.w          = w;
    n.d          = d;
    if (op2 == SP || op2 == CT) note_q.push_back(n);
    seed = lfsr(seed);
    u_vcibc_core_model.access(wr, el, op2, wd, cx);
  endtask

  task automatic settle(input string name);
    u_vcibc_core_model.idle();
    repeat (3) @(negedge clock_i);
    $display("test %s done", name);
  endtask

  task automatic end_of_test();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Every response or group 0 write must match the oldest note
  always @(posedge clock_i) begin
    #1;
    if (resp.valid === 1'b1 || vg0_wr === 1'b1) begin
      if (note_q.size() == 0) begin
        error_cnt++;
        $display("BAD t=%0t got=%h exp=none", $time, resp);
      end else begin
        exp = note_q.pop_front();
        got = {resp, vg0_wr, exp.w ? vg0_wd : 3'h0};
        chk_note(got, exp);
      end
    end
  end

  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (3) @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk_mask(3'h3);
    chk_val({63'h0, mode}, 64'h0);
    chk_val({63'h0, common_split_point}, 64'h0);
    run(1'b0, 2'h1, SP, 64'h0, VN, 2'h0, 2'h0, 64'h3);
    settle("reset");
    for (int v = 0; v < 8; v++) begin
      exp3 = (v < 3) ? 3'h3 : 3'(v);
      run(1'b1, 2'h1, SP, {seed, seed, seed, 13'(seed), 3'(v)}, VN, 2'h0, 2'h0, 64'h0);
      run(1'b0, 2'h1, SP, 64'h0, VN, 2'h0, 2'h0, {61'h0, exp3});
      settle("split");
      chk_mask(exp3);
    end
    run(1'b1, 2'h3, SP, 64'h5, PS, 2'h0, 2'h0, 64'h0);
    run(1'b1, 2'h3, SP, 64'h6, PN, 2'h0, 2'h0, 64'h0);
    run(1'b0, 2'h3, SP, 64'h0, PS, 2'h0, 2'h0, 64'h5);
    run(1'b0, 2'h2, SP, 64'h0, PN, 2'h0, 2'h0, 64'h6);
    settle("copies");
    run(1'b1, 2'h0, SP, 64'h7, VN, 2'h1, 2'h0, 64'h0);
    run(1'b1, 2'h1, SP, 64'h7, 12'h691, 2'h3, 2'h1, 64'h0);
    run(1'b1, 2'h1, SP, 64'h7, 12'h7d1, 2'h3, 2'h1, 64'h0);
    run(1'b0, 2'h1, SP, 64'h0, 12'hfd1, 2'h3, 2'h2, 64'h0);
    run(1'b1, 2'h3, SP, 64'h7, 12'hc80, 2'h3, 2'h3, 64'h0);
    run(1'b1, 2'h1, SP, 64'h7, 12'he85, 2'h3, 2'h3, 64'h0);
    run(1'b1, 2'h2, SP, 64'h7, 12'ha85, 2'h3, 2'h2, 64'h0);
    run(1'b1, 2'h2, SP, 64'h7, 12'he85, 2'h3, 2'h3, 64'h0);
    run(1'b1, 2'h1, 3'h5, 64'h4, VN, 2'h0, 2'h0, 64'h0);
    run(1'b0, 2'h3, SP, 64'h0, PN, 2'h0, 2'h0, 64'h6);
    run(1'b0, 2'h1, SP, 64'h0, 12'hf95, 2'h0, 2'h0, 64'h7);
    settle("routing");
    // With the enable low the write must be lost and no answer given
    ce_i = 1'b0;
    u_vcibc_core_model.access(1'b1, 2'h1, SP, 64'h4, VN);
    settle("freeze");
    ce_i = 1'b1;
    chk_mask(3'h7);
    run(1'b0, 2'h1, SP, 64'h0, VN, 2'h0, 2'h0, 64'h7);
    run(1'b1, 2'h1, CT, {64{1'b1}}, VN, 2'h0, 2'h0, 64'h0);
    // Feature fields follow the parameters given to the instance above
    run(1'b0, 2'h1, CT, 64'h0, VN, 2'h0, 2'h0,
        {44'h0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 3'h1, 3'h4, 6'h0, 2'h3});
    settle("control");
    chk_val({63'h0, mode}, 64'h1);
    chk_val({63'h0, common_split_point}, 64'h1);
    vg0 = 3'h4;
    run(1'b0, 2'h1, SP, 64'h0, VN, 2'h0, 2'h0, 64'h5);
    run(1'b1, 2'h1, SP, 64'h2, VN, 2'h0, 2'h0, 64'h0);
    settle("common");
    chk_mask(3'h5);
    vg0 = 3'h7;
    run(1'b0, 2'h1, SP, 64'h0, VN, 2'h0, 2'h0, 64'h7);
    run(1'b0, 2'h1, SP, 64'h0, VS, 2'h0, 2'h0, 64'h7);
    run(1'b1, 2'h1, SP, 64'h6, VS, 2'h0, 2'h0, 64'h0, 1'b1, 3'h6);
    run(1'b1, 2'h1, CT, 64'h0, VN, 2'h0, 2'h0, 64'h0);
    // Group 0 moves so a stuck common split would read 4, not 7
    vg0 = 3'h3;
    run(1'b0, 2'h1, SP, 64'h0, VN, 2'h0, 2'h0, 64'h7);
    settle("separate");
    resetn_i = 1'b0;
    @(negedge clock_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk_mask(3'h3);
    run(1'b0, 2'h1, SP, 64'h0, VN, 2'h0, 2'h0, 64'h3);
    settle("reset again");
    chk_val(64'(note_q.size()), 64'h0);
    end_of_test();
  end
endmodule // tb
